/* File: hw/flash_timebase.sv */
// Shared flash timebase: a tick every half fast period and a 3-bit phase.
// Assumes one clock; restart realigns all rates at once.
`timescale 1ns/10ps
`default_nettype none
`include "led_annunciator_params.svh"
module flash_timebase #(
  parameter int unsigned TICK_CYCLES = `FLASH_TICK_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       restart,
  output logic            tick,
  output logic [2:0]      phase
);

  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

  logic [CW-1:0] cnt_q;
  logic [2:0]    phase_q;

  assign tick  = (cnt_q == CW'(TICK_CYCLES - 1)) && !restart;
  assign phase = phase_q;

  // RULE14 one shared timebase
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || restart)
    begin
      cnt_q   <= '0;
      phase_q <= 3'h0;
    end
    else if (tick)
    begin
      cnt_q   <= '0;
      phase_q <= phase_q + 3'h1;
    end
    else
    begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

endmodule

`default_nettype wire

/* File: hw/key_hold.sv */
// Key input conditioner: two-stage synchroniser, press edge and long-hold pulse.
// Assumes an active-low push-button pin from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
`include "led_annunciator_params.svh"
module key_hold #(
  parameter int unsigned HOLD_CYCLES = `LAMP_HOLD_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic key_n,
  output logic      press,
  output logic      hold
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  logic          meta_q;
  logic          sync_q;
  logic          prev_q;
  logic [CW-1:0] held_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= ~key_n;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign press = sync_q && !prev_q;
  assign hold  = sync_q && (held_q == CW'(HOLD_CYCLES - 1));

  // RULE11 continuous hold count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !sync_q)
    begin
      held_q <= '0;
    end
    else if (held_q != CW'(HOLD_CYCLES))
    begin
      held_q <= held_q + CW'(1);
    end
  end

endmodule

`default_nettype wire

/* File: hw/led_annunciator_control.sv */
// Indicator and key handling for the detector front control unit.
// Assumes detection logic on the same clock supplies the condition levels,
// keys are raw active-low pins, and software uses a plain register port.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "led_annunciator_params.svh"
// Operation
// RULE1 - Drive separate operation, fault, alarm and dusty/dirty indicator LEDs.
// RULE2 - Each LED shows off, slow 2 s, medium 1 s, fast 0.5 s, or on.
// RULE3 - Operation LED steady while powered, dark without power.
// RULE4 - Alarm LED slow, medium, fast for pre-signal 1 to 3; steady on alarm.
// RULE5 - Fault LED medium while pipe blockage/breakage delay runs.
// RULE6 - Fault LED fast when system inactive or sensor off by fire panel.
// RULE7 - Fault LED steady once a fault is triggered and latched.
// RULE8 - Dusty/dirty LED medium for dusty, fast for dirty, steady for sensor fault.
// RULE9 - Reset key clears latched alarm and fault events and indications.
// RULE10 - A latched event whose cause persists is not cleared.
// RULE11 - Holding either reset key ten seconds starts a lamp test.
// RULE12 - Lamp test flashes all LEDs five times except watchdog, then resumes.
// RULE13 - Most severe pattern wins: on, then fast, medium, slow.
// RULE14 - Flashing is fifty percent duty from one shared timebase.
module led_annunciator_control #(
  parameter int unsigned TICK_CYCLES = `FLASH_TICK_CYCLES,
  parameter int unsigned HOLD_CYCLES = `LAMP_HOLD_CYCLES,
  parameter int unsigned BOARD_LEDS  = 4
) (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire led_annunciator_pkg::cond_t     cond,
  input  wire logic                           front_key_n,
  input  wire logic                           board_key_n,
  input  wire logic [BOARD_LEDS-1:0]          board_led_in,
  input  wire logic                           wdog_led_in,
  input  wire logic [7:0]                     addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr_en,
  input  wire logic                           rd_en,
  output logic [31:0]                         rdata_q,
  output logic                                led_op_q,
  output logic                                led_fault_q,
  output logic                                led_alarm_q,
  output logic                                led_dust_q,
  output logic [BOARD_LEDS-1:0]               board_led_q,
  output logic                                wdog_led_q
);

  logic                              front_press;
  logic                              front_hold;
  logic                              board_press;
  logic                              board_hold;
  logic                              tick;
  logic [2:0]                        phase;
  logic                              tb_restart;
  logic                              clear_req;
  logic                              lamp_req;
  logic                              sw_clear;
  logic                              sw_lamp;
  logic                              alarm_latch_q;
  logic                              fault_latch_q;
  logic                              sensor_latch_q;
  led_annunciator_pkg::lamp_state_t  lamp_state_q;
  logic [2:0]                        flash_cnt_q;
  logic                              lamp_done;
  led_annunciator_pkg::pattern_t     op_pat;
  led_annunciator_pkg::pattern_t     fault_pat;
  led_annunciator_pkg::pattern_t     alarm_pat;
  led_annunciator_pkg::pattern_t     dust_pat;
  logic                              lamp_lit;

  key_hold #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_front_key (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .key_n   (front_key_n),
    .press   (front_press),
    .hold    (front_hold)
  );

  key_hold #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_board_key (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .key_n   (board_key_n),
    .press   (board_press),
    .hold    (board_hold)
  );

  flash_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .restart (tb_restart),
    .tick    (tick),
    .phase   (phase)
  );

  // Software pulses share the key paths so both act identically.
  assign sw_clear = wr_en && (addr == `REG_CTRL) && wdata[`CTRL_EVENT_CLEAR];
  assign sw_lamp  = wr_en && (addr == `REG_CTRL) && wdata[`CTRL_LAMP_START];

  // RULE9 reset key clears
  assign clear_req = front_press || board_press || sw_clear;

  // RULE11 long hold starts
  assign lamp_req = front_hold || board_hold || sw_lamp;

  // A clear never beats a live cause, so a persisting event stays latched without dropping.
  // RULE10 cause keeps latch
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      alarm_latch_q <= 1'b0;
    end
    else
    begin
      alarm_latch_q <= cond.smoke_alarm || (alarm_latch_q && !clear_req);
    end
  end

  // RULE7 fault latches steady
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fault_latch_q <= 1'b0;
    end
    else
    begin
      fault_latch_q <= cond.pipe_fault || cond.fan_tacho_missing
                       || (fault_latch_q && !clear_req);
    end
  end

  // RULE10 sensor fault latch
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sensor_latch_q <= 1'b0;
    end
    else
    begin
      sensor_latch_q <= cond.sensor_fault || (sensor_latch_q && !clear_req);
    end
  end

  // Larger code is the more severe pattern.
  function automatic led_annunciator_pkg::pattern_t pat_max(
    input led_annunciator_pkg::pattern_t a,
    input led_annunciator_pkg::pattern_t b
  );
    pat_max = (a > b) ? a : b;
  endfunction

  function automatic logic pat_lit(
    input led_annunciator_pkg::pattern_t p,
    input logic [2:0]                    ph
  );
    case (p)
      led_annunciator_pkg::PAT_OFF:  pat_lit = 1'b0;
      led_annunciator_pkg::PAT_SLOW: pat_lit = ~ph[2];
      led_annunciator_pkg::PAT_MED:  pat_lit = ~ph[1];
      led_annunciator_pkg::PAT_FAST: pat_lit = ~ph[0];
      led_annunciator_pkg::PAT_ON:   pat_lit = 1'b1;
      default:                       pat_lit = 1'b0;
    endcase
  endfunction

  // RULE3 operation follows power
  always_comb
  begin
    op_pat = cond.power_ok ? led_annunciator_pkg::PAT_ON : led_annunciator_pkg::PAT_OFF;
  end

  // RULE4 alarm patterns
  // RULE13 most severe wins
  always_comb
  begin
    alarm_pat = led_annunciator_pkg::PAT_OFF;
    if (cond.presignal1)
    begin
      alarm_pat = pat_max(alarm_pat, led_annunciator_pkg::PAT_SLOW);
    end
    if (cond.presignal2)
    begin
      alarm_pat = pat_max(alarm_pat, led_annunciator_pkg::PAT_MED);
    end
    if (cond.presignal3)
    begin
      alarm_pat = pat_max(alarm_pat, led_annunciator_pkg::PAT_FAST);
    end
    if (alarm_latch_q)
    begin
      alarm_pat = led_annunciator_pkg::PAT_ON;
    end
  end

  // RULE5 pipe delay medium
  // RULE6 inactive fast
  always_comb
  begin
    fault_pat = led_annunciator_pkg::PAT_OFF;
    if (cond.pipe_delay_running)
    begin
      fault_pat = pat_max(fault_pat, led_annunciator_pkg::PAT_MED);
    end
    if (cond.sys_inactive || cond.sensor_off_by_fire_panel)
    begin
      fault_pat = pat_max(fault_pat, led_annunciator_pkg::PAT_FAST);
    end
    if (fault_latch_q)
    begin
      fault_pat = led_annunciator_pkg::PAT_ON;
    end
  end

  // RULE8 dusty dirty sensor
  always_comb
  begin
    dust_pat = led_annunciator_pkg::PAT_OFF;
    if (cond.dusty)
    begin
      dust_pat = pat_max(dust_pat, led_annunciator_pkg::PAT_MED);
    end
    if (cond.dirty)
    begin
      dust_pat = pat_max(dust_pat, led_annunciator_pkg::PAT_FAST);
    end
    if (sensor_latch_q)
    begin
      dust_pat = led_annunciator_pkg::PAT_ON;
    end
  end

  // Restarting the shared timebase makes every lamp-test flash whole; normal
  // indicators lose at most one partial flash, which is an accepted trade.
  assign tb_restart = lamp_req && (lamp_state_q == led_annunciator_pkg::LT_IDLE);

  // One flash ends each time the medium phase falls from dark back to lit.
  assign lamp_done = tick && (phase[1:0] == 2'h3)
                     && (flash_cnt_q == 3'(`LAMP_FLASHES - 1));

  // RULE12 five flashes
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      lamp_state_q <= led_annunciator_pkg::LT_IDLE;
      flash_cnt_q  <= 3'h0;
    end
    else
    begin
      case (lamp_state_q)
        led_annunciator_pkg::LT_IDLE:
        begin
          flash_cnt_q <= 3'h0;
          if (lamp_req)
          begin
            lamp_state_q <= led_annunciator_pkg::LT_RUN;
          end
        end
        led_annunciator_pkg::LT_RUN:
        begin
          if (lamp_done)
          begin
            lamp_state_q <= led_annunciator_pkg::LT_IDLE;
          end
          else if (tick && (phase[1:0] == 2'h3))
          begin
            flash_cnt_q <= flash_cnt_q + 3'h1;
          end
        end
        default:
        begin
          lamp_state_q <= led_annunciator_pkg::LT_IDLE;
        end
      endcase
    end
  end

  assign lamp_lit = ~phase[1];

  // RULE1 separate indicator LEDs
  // RULE2 five patterns
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      led_op_q    <= 1'b0;
      led_fault_q <= 1'b0;
      led_alarm_q <= 1'b0;
      led_dust_q  <= 1'b0;
    end
    else if (lamp_state_q == led_annunciator_pkg::LT_RUN)
    begin
      led_op_q    <= lamp_lit;
      led_fault_q <= lamp_lit;
      led_alarm_q <= lamp_lit;
      led_dust_q  <= lamp_lit;
    end
    else
    begin
      led_op_q    <= pat_lit(op_pat, phase);
      led_fault_q <= pat_lit(fault_pat, phase);
      led_alarm_q <= pat_lit(alarm_pat, phase);
      led_dust_q  <= pat_lit(dust_pat, phase);
    end
  end

  // The watchdog LED must keep showing real health, so the test never touches it.
  // RULE12 board LEDs flash
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      board_led_q <= '0;
      wdog_led_q  <= 1'b0;
    end
    else
    begin
      wdog_led_q <= wdog_led_in;
      if (lamp_state_q == led_annunciator_pkg::LT_RUN)
      begin
        board_led_q <= {BOARD_LEDS{lamp_lit}};
      end
      else
      begin
        board_led_q <= board_led_in;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (rd_en)
    begin
      rdata_q <= 32'h0000_0000;
      case (addr)
        `REG_STATUS:
        begin
          rdata_q[`STAT_ALARM]        <= alarm_latch_q;
          rdata_q[`STAT_FAULT]        <= fault_latch_q;
          rdata_q[`STAT_SENSOR_FAULT] <= sensor_latch_q;
          rdata_q[`STAT_LAMP_TEST]    <= (lamp_state_q == led_annunciator_pkg::LT_RUN);
          rdata_q[`STAT_POWER]        <= cond.power_ok;
        end
        `REG_LED_VIEW:
        begin
          rdata_q[`VIEW_OP_LSB +: 3]    <= op_pat;
          rdata_q[`VIEW_FAULT_LSB +: 3] <= fault_pat;
          rdata_q[`VIEW_ALARM_LSB +: 3] <= alarm_pat;
          rdata_q[`VIEW_DUST_LSB +: 3]  <= dust_pat;
        end
        default:
        begin
          rdata_q <= 32'h0000_0000;
        end
      endcase
    end
    else
    begin
      rdata_q <= 32'h0000_0000;
    end
  end

endmodule

`default_nettype wire

/* File: hw/led_annunciator_params.svh */
// Constants for the indicator and key-handling block: timing and register map.
// Assumes a single 40 MHz system clock; included by bare name.
`ifndef LED_ANNUNCIATOR_PARAMS_SVH
`define LED_ANNUNCIATOR_PARAMS_SVH

`define CLK_HZ            40000000
`define FAST_PERIOD_MS    500
`define MED_PERIOD_MS     1000
`define SLOW_PERIOD_MS    2000
// One tick per half fast period; medium and slow are binary multiples of it.
`define FLASH_TICK_CYCLES ((`CLK_HZ / 1000) * (`FAST_PERIOD_MS / 2))
`define LAMP_HOLD_S       10
`define LAMP_HOLD_CYCLES  (`CLK_HZ * `LAMP_HOLD_S)
`define LAMP_FLASHES      5

`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_LED_VIEW      8'h08

`define CTRL_EVENT_CLEAR  0
`define CTRL_LAMP_START   1

`define STAT_ALARM        0
`define STAT_FAULT        1
`define STAT_SENSOR_FAULT 2
`define STAT_LAMP_TEST    3
`define STAT_POWER        4

`define VIEW_OP_LSB       0
`define VIEW_FAULT_LSB    3
`define VIEW_ALARM_LSB    6
`define VIEW_DUST_LSB     9

`endif

/* File: hw/led_annunciator_pkg.sv */
// Types shared by the indicator block and its helpers.
// Assumes nothing beyond a SystemVerilog compiler.
package led_annunciator_pkg;

  // Encoded in order of severity so that a larger code wins.
  typedef enum logic [2:0] {
    PAT_OFF  = 3'b000,
    PAT_SLOW = 3'b001,
    PAT_MED  = 3'b010,
    PAT_FAST = 3'b011,
    PAT_ON   = 3'b100
  } pattern_t;

  typedef enum logic [0:0] {
    LT_IDLE = 1'b0,
    LT_RUN  = 1'b1
  } lamp_state_t;

  typedef struct packed {
    logic power_ok;
    logic presignal1;
    logic presignal2;
    logic presignal3;
    logic smoke_alarm;
    logic pipe_delay_running;
    logic sys_inactive;
    logic sensor_off_by_fire_panel;
    logic pipe_fault;
    logic fan_tacho_missing;
    logic dusty;
    logic dirty;
    logic sensor_fault;
  } cond_t;

endpackage

/* File: tb/led_annunciator_control_assertions.sv */
// Concurrent checks on the ports of the indicator block.
// Assumes it is bound to led_annunciator_control with matching parameters.
`timescale 1ns/10ps
`default_nettype none

module led_annunciator_control_assertions #(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned HOLD_CYCLES = 20
) (
  input wire logic                       clk_sys,
  input wire logic                       rst_n,
  input wire led_annunciator_pkg::cond_t cond,
  input wire logic                       front_key_n,
  input wire logic                       board_key_n,
  input wire logic [7:0]                 addr,
  input wire logic                       wr_en,
  input wire logic                       rd_en,
  input wire logic [31:0]                rdata_q,
  input wire logic                       led_op_q,
  input wire logic                       led_fault_q,
  input wire logic                       led_alarm_q,
  input wire logic                       led_dust_q,
  input wire logic                       wdog_led_in,
  input wire logic                       wdog_led_q
);
  localparam int QUIET = 20 * TICK_CYCLES + HOLD_CYCLES + 8;
  int                         idle_q;
  int                         still_q;
  led_annunciator_pkg::cond_t cond_q;
  logic                       quiet;

  // A lamp test overrides every panel LED, so level checks wait until none can run.
  always_ff @(posedge clk_sys)
    if (!rst_n || !front_key_n || !board_key_n || (wr_en && addr == 8'h00))
      idle_q <= 0;
    else if (idle_q < QUIET)
      idle_q <= idle_q + 1;

  always_ff @(posedge clk_sys)
  begin
    cond_q  <= cond;
    still_q <= (cond != cond_q) ? 0 : ((still_q < 15) ? still_q + 1 : still_q);
  end

  assign quiet = (idle_q >= QUIET);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_wdog_copy;
    $past(rst_n) |-> wdog_led_q == $past(wdog_led_in);
  endproperty
  a_wdog_copy: assert property (p_wdog_copy)
    else $error("watchdog led is not a delayed copy");

  property p_op_power;
    quiet |-> ##1 (led_op_q == $past(cond.power_ok));
  endproperty
  a_op_power: assert property (p_op_power)
    else $error("operation led does not follow power");

  property p_alarm_on;
    quiet && cond.smoke_alarm |-> ##2 led_alarm_q;
  endproperty
  a_alarm_on: assert property (p_alarm_on)
    else $error("alarm led not steady on alarm");

  property p_fault_on;
    quiet && (cond.pipe_fault || cond.fan_tacho_missing) |-> ##2 led_fault_q;
  endproperty
  a_fault_on: assert property (p_fault_on)
    else $error("fault led not steady on fault");

  property p_dust_on;
    quiet && cond.sensor_fault |-> ##2 led_dust_q;
  endproperty
  a_dust_on: assert property (p_dust_on)
    else $error("dusty led not steady on sensor fault");

  property p_rd_idle;
    !rd_en |=> rdata_q == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data present without a read");

  property p_rd_unmapped;
    rd_en && addr != 8'h04 && addr != 8'h08 |=> rdata_q == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("write-only or unmapped place read nonzero");

  property p_flash_min;
    quiet && still_q > 4 && $changed(led_alarm_q) |=> ($stable(led_alarm_q) || still_q < 2) [*3];
  endproperty
  a_flash_min: assert property (p_flash_min)
    else $error("alarm led toggles faster than one tick");
endmodule

`default_nettype wire

/* File: tb/led_annunciator_control_bench.sv */
// Self-checking bench for the indicator block with a front panel model.
// Assumes shortened tick and hold counts; a bench model predicts the status and view reads.
`timescale 1ns/10ps
`default_nettype none

module led_annunciator_control_bench;
  localparam int TICK = 4;
  localparam int HOLD = 20;
  logic                       clk_sys = 1'b0;
  logic                       rst_n = 1'b0;
  led_annunciator_pkg::cond_t cond = '0;
  logic [3:0]                 board_led_in = 4'h0;
  logic                       wdog_led_in = 1'b0;
  logic [7:0]                 addr = 8'h00;
  logic [31:0]                wdata = 32'h0;
  logic                       wr_en = 1'b0;
  logic                       rd_en = 1'b0;
  logic                       press_front = 1'b0;
  logic                       press_board = 1'b0;
  logic                       clr = 1'b0;
  logic [31:0]                rdata_q;
  logic                       led_op_q;
  logic                       led_fault_q;
  logic                       led_alarm_q;
  logic                       led_dust_q;
  logic                       wdog_led_q;
  logic [3:0]                 board_led_q;
  logic                       front_key_n;
  logic                       board_key_n;
  logic [31:0]                got;
  int                         rises [5];
  int                         gap [5];
  int                         fails = 0;
  int                         check_count = 0;
  int                         cycles = 0;
  int                         al = 0;
  int                         fl = 0;
  int                         sl = 0;

  always #12.5 clk_sys = ~clk_sys;

  led_annunciator_control #(.TICK_CYCLES(TICK), .HOLD_CYCLES(HOLD), .BOARD_LEDS(4))
    led_annunciator_control_i (.clk_sys(clk_sys), .rst_n(rst_n), .cond(cond),
    .front_key_n(front_key_n), .board_key_n(board_key_n), .board_led_in(board_led_in),
    .wdog_led_in(wdog_led_in), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata_q(rdata_q), .led_op_q(led_op_q), .led_fault_q(led_fault_q),
    .led_alarm_q(led_alarm_q), .led_dust_q(led_dust_q), .board_led_q(board_led_q),
    .wdog_led_q(wdog_led_q));

  panel_model panel_model_i (.clk_sys(clk_sys), .press_front(press_front),
    .press_board(press_board), .clr(clr),
    .leds({board_led_q[0], led_dust_q, led_alarm_q, led_fault_q, led_op_q}),
    .front_key_n(front_key_n), .board_key_n(board_key_n), .rises(rises), .gap(gap));

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    wdog_led_in <= 1'($urandom);
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic chk_panel(string n, int e, int g);
    check_count++;
    if (g != e)
    begin
      fails++;
      $display("unexpected %s: expected %0d, seen %0d", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 d = rdata_q;
  endtask

  task automatic apply(led_annunciator_pkg::cond_t c);
    @(posedge clk_sys);
    cond <= c;
    al = al | int'(c.smoke_alarm);
    fl = fl | int'(c.pipe_fault | c.fan_tacho_missing);
    sl = sl | int'(c.sensor_fault);
  endtask

  // A clear is refused for any latch whose cause is still present.
  task automatic clear_model();
    al = al & int'(cond.smoke_alarm);
    fl = fl & int'(cond.pipe_fault | cond.fan_tacho_missing);
    sl = sl & int'(cond.sensor_fault);
  endtask

  task automatic press(int front, int n);
    @(posedge clk_sys);
    press_front <= (front == 1);
    press_board <= (front != 1);
    repeat (n) @(posedge clk_sys);
    press_front <= 1'b0;
    press_board <= 1'b0;
  endtask

  task automatic check_view(logic [31:0] lamp);
    int op;
    int ft;
    int am;
    int du;
    op = cond.power_ok ? 4 : 0;
    ft = fl ? 4 : (cond.sys_inactive || cond.sensor_off_by_fire_panel) ? 3 :
         cond.pipe_delay_running ? 2 : 0;
    am = al ? 4 : cond.presignal3 ? 3 : cond.presignal2 ? 2 : cond.presignal1 ? 1 : 0;
    du = sl ? 4 : cond.dirty ? 3 : cond.dusty ? 2 : 0;
    rd(8'h08, got);
    chk_reg("led view", 32'(du * 512 + am * 64 + ft * 8 + op), got);
    rd(8'h04, got);
    chk_reg("status", lamp | 32'(int'(cond.power_ok) * 16 + sl * 4 + fl * 2 + al), got);
  endtask

  initial
  begin
    led_annunciator_pkg::cond_t c;
    int k;
    void'($urandom(32'hEA332C5C));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(8'h0C, got);
    chk_reg("unmapped read", 32'h0, got);
    rd(8'h00, got);
    chk_reg("control read", 32'h0, got);
    repeat (40)
    begin
      c = led_annunciator_pkg::cond_t'(13'($urandom & $urandom & $urandom));
      c.power_ok = 1'($urandom);
      board_led_in <= 4'($urandom);
      apply(c);
      k = $urandom_range(3, 0);
      if (k == 0)
        wr(8'h00, 32'h1);
      else if (k < 3)
        press(k, 4);
      if (k < 3)
        clear_model();
      repeat (4) @(posedge clk_sys);
      check_view(32'h0);
      chk_reg("board leds", 32'(board_led_in), 32'(board_led_q));
    end
    c = '0;
    c.power_ok = 1'b1;
    c.presignal1 = 1'b1;
    c.pipe_delay_running = 1'b1;
    c.dirty = 1'b1;
    board_led_in <= 4'h0;
    apply(c);
    wr(8'h00, 32'h1);
    clear_model();
    repeat (150) @(posedge clk_sys);
    check_view(32'h0);
    chk_panel("slow half period", 4 * TICK, gap[2]);
    chk_panel("medium half period", 2 * TICK, gap[1]);
    chk_panel("fast half period", TICK, gap[3]);
    c.smoke_alarm = 1'b1;
    c.pipe_fault = 1'b1;
    c.sensor_fault = 1'b1;
    apply(c);
    repeat (5) @(posedge clk_sys);
    wr(8'h00, 32'h1);
    clear_model();
    check_view(32'h0);
    c = '0;
    c.power_ok = 1'b1;
    apply(c);
    repeat (3) @(posedge clk_sys);
    check_view(32'h0);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    press(1, HOLD + 6);
    clear_model();
    rd(8'h04, got);
    chk_reg("lamp running", 32'h18, got);
    repeat (20 * TICK + 20) @(posedge clk_sys);
    chk_panel("panel flashes", 5, rises[1]);
    chk_panel("board flashes", 5, rises[4]);
    check_view(32'h0);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    wr(8'h00, 32'h2);
    repeat (20 * TICK + 10) @(posedge clk_sys);
    chk_panel("alarm flashes", 5, rises[2]);
    check_view(32'h0);
    complete_run();
  end
endmodule

bind led_annunciator_control led_annunciator_control_assertions #(
  .TICK_CYCLES(TICK_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) chk_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .cond(cond), .front_key_n(front_key_n), .board_key_n(board_key_n),
  .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .led_op_q(led_op_q),
  .led_fault_q(led_fault_q), .led_alarm_q(led_alarm_q), .led_dust_q(led_dust_q),
  .wdog_led_in(wdog_led_in), .wdog_led_q(wdog_led_q));

`default_nettype wire

/* File: tb/panel_model.sv */
// Front panel model: pulled-up push-buttons and an observer on the LEDs.
// Assumes the bench asks for presses as levels on the system clock.
`timescale 1ns/10ps
`default_nettype none

module panel_model (
  input  wire logic       clk_sys,
  input  wire logic       press_front,
  input  wire logic       press_board,
  input  wire logic       clr,
  input  wire logic [4:0] leds,
  output logic            front_key_n,
  output logic            board_key_n,
  output int              rises [5],
  output int              gap [5]
);
  logic [4:0] last_q = 5'h00;
  int         since [5];

  initial
  begin
    front_key_n = 1'b1;
    board_key_n = 1'b1;
  end

  // key held low
  // A released key returns to its pull-up level; holding lasts as long as asked.
  always @(posedge clk_sys)
  begin
    front_key_n <= ~press_front;
    board_key_n <= ~press_board;
  end

  // The gap between toggles gives the half period without knowing the phase.
  always @(posedge clk_sys)
  begin
    last_q <= leds;
    for (int i = 0; i < 5; i++)
    begin
      if (clr)
      begin
        rises[i] <= 0;
        gap[i]   <= 0;
        since[i] <= 0;
      end
      else if (leds[i] != last_q[i])
      begin
        gap[i]   <= since[i];
        since[i] <= 1;
        if (leds[i])
          rises[i] <= rises[i] + 1;
      end
      else
        since[i] <= since[i] + 1;
    end
  end
endmodule

`default_nettype wire
